//--- core/cca_consts.vh
`ifndef CCA_CONSTS_VH
`define CCA_CONSTS_VH

// Register offsets
`define CCA_ADDR_STATUS 6'h01
`define CCA_ADDR_CONFIG 6'h08
`define CCA_ADDR_THRESH 6'h09

// Channel configuration fields
`define CCA_TRIGGER_BIT 7
`define CCA_SELECT_HI 6
`define CCA_SELECT_LO 5
`define CCA_CHANNEL_HI 4
`define CCA_CHANNEL_LO 0
`define CCA_SELECT_RESET 2'h1
`define CCA_CHANNEL_RESET 5'h0B

// Threshold field
`define CCA_LIMIT_HI 3
`define CCA_LIMIT_LO 0
`define CCA_LIMIT_RESET 4'h7

// Status fields
`define ASSESSMENT_COMPLETE_BIT 7
`define CCA_IDLE_BIT 6

// Assessment select codes
`define CCA_SEL_OR 2'h0
`define CCA_SEL_ENERGY 2'h1
`define CCA_SEL_CARRIER 2'h2
`define CCA_SEL_AND 2'h3

// Timing: clock period, measurement window and result deadline, in ns
`define CCA_CLK_PERIOD_NS 25
`define CCA_MEAS_TIME_NS 128000
`define CCA_DEADLINE_NS 180000
// Least time rounds up, longest time rounds down
`define CCA_MEAS_CYCLES ((`CCA_MEAS_TIME_NS + `CCA_CLK_PERIOD_NS - 1) / `CCA_CLK_PERIOD_NS)
`define CCA_DEADLINE_CYCLES (`CCA_DEADLINE_NS / `CCA_CLK_PERIOD_NS)

`endif

//--- core/busy_decide.v
`timescale 1ns/1ps
module busy_decide (
    // Mode and detector inputs
    input wire [1:0] select,
    input wire carrier_seen,
    input wire energy_seen,
    // Decision
    output reg busy
);
`include "cca_consts.vh"

    // Mode table for the busy decision
    always @* begin
        case (select)
            `CCA_SEL_OR: busy = carrier_seen | energy_seen;
            `CCA_SEL_ENERGY: busy = energy_seen;
            `CCA_SEL_CARRIER: busy = carrier_seen;
            `CCA_SEL_AND: busy = carrier_seen & energy_seen;
            default: busy = 1'b1;
        endcase
    end
endmodule

//--- core/clear_channel_assessment.v
`timescale 1ns/1ps
// Overview of operation
// - Mode 1: busy when energy above limit
// - Mode 2: busy only on carrier detection
// - Mode 0 ORs, mode 3 ANDs both
// - Trigger bit in config register starts assessment
// - Result ready within 180us, 128us window
// - Completion raises shared measurement-done interrupt
// - Busy above floor plus 2dB times limit
// - Status bits readable, cleared by new trigger
// - Complete set; idle flag set if the mode's decision is not busy in a receive state
// - Carrier modes flag detected frames as busy; busy receive counts a carrier if carrier_detect is high at trigger or during the auto measurement wait
// - Outside receive states: complete without measuring
// - Listen state: eight-symbol window, then complete
// - Busy receive: timing depends on mode, sync
// - Energy modes wait for running auto measurement
// - Carrier-only mode answers at once
// - Preamble detect off keeps listen timing
// - Trigger reads zero, clears itself
// - Select field bits 6:5, resets to 1
// - Limit field bits 3:0, resets to 7
// - Complete bit 7, idle bit 6, reset 0
`include "cca_consts.vh"

module clear_channel_assessment #(
    parameter MEAS_CYCLES = `CCA_MEAS_CYCLES,
    parameter DEADLINE_CYCLES = `CCA_DEADLINE_CYCLES,
    parameter CNT_W = 13
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Register access port
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    // Receiver state
    input wire [4:0] trx_state_code,
    input wire basic_mode,
    input wire rx_listen,
    input wire rx_busy,
    input wire preamble_detect_off,
    // Detectors
    input wire carrier_detect,
    input wire auto_meas_active,
    input wire meas_done,
    input wire [7:0] meas_level,
    // Measurement request, channel and interrupt
    output reg meas_start,
    output wire [4:0] channel_number,
    output reg done_irq
);

    // Sequencer states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_LISTEN = 2'h1;
    localparam [1:0] ST_WAIT_AUTO = 2'h2;
    localparam [1:0] ST_FINISH = 2'h3;

    // Counter end points; the deadline point leaves the finishing and
    // status cycles inside the result deadline
    localparam integer MEAS_LAST_I = MEAS_CYCLES - 1;
    localparam integer DEAD_LAST_I = DEADLINE_CYCLES - 2;
    localparam [CNT_W-1:0] MEAS_LAST = MEAS_LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] DEAD_LAST = DEAD_LAST_I[CNT_W-1:0];

    // Stored fields, status, timer and detector captures
    reg [1:0] state;
    reg [1:0] next_state;
    reg [1:0] select;
    reg [4:0] channel;
    reg [3:0] limit;
    reg complete;
    reg idle_flag;
    reg [CNT_W-1:0] count;
    reg carrier_seen;
    reg energy_seen;
    reg level_seen;
    reg [7:0] last_level;
    reg measured;

    // Decoded requests and decision nets
    wire trigger;
    wire accept;
    wire finishing;
    wire listening;
    wire in_receive;
    wire level_busy;
    wire last_busy;
    wire final_busy;
    wire [7:0] limit_db;
    wire [1:0] req_select;
    wire watching;

    // Config writes with a one in the trigger bit request an assessment
    assign trigger = reg_write && (reg_addr == `CCA_ADDR_CONFIG) &&
                     reg_wdata[`CCA_TRIGGER_BIT];
    assign finishing = (state == ST_FINISH);
    // A completion in progress wins over a colliding trigger
    assign accept = trigger && !finishing;
    // Path choice uses the mode carried by the trigger write itself
    assign req_select = reg_wdata[`CCA_SELECT_HI:`CCA_SELECT_LO];
    assign watching = (state == ST_LISTEN) || (state == ST_WAIT_AUTO);

    // Channel field is only stored and passed on
    assign channel_number = channel;

    // Receive states only count in the basic operating mode;
    // preamble detection off means the receiver never leaves listening
    assign listening = rx_listen || (rx_busy && preamble_detect_off);
    assign in_receive = basic_mode && (rx_listen || rx_busy);

    // Limit is in 2 dB steps above the floor; level is 1 dB above floor
    // Both sides count from the floor, so no offset is needed
    assign limit_db = {3'h0, limit, 1'b0};
    assign level_busy = meas_level > limit_db;
    assign last_busy = last_level > limit_db;

    // Shared mode table
    // Stored mode already holds the written one when the result forms
    busy_decide u_decide (
        .select(select),
        .carrier_seen(carrier_seen),
        .energy_seen(energy_seen),
        .busy(final_busy)
    );

    // Configuration registers; trigger bit is never stored
    // A new limit applies to the next comparison, even mid-run
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            select <= `CCA_SELECT_RESET;
            channel <= `CCA_CHANNEL_RESET;
            limit <= `CCA_LIMIT_RESET;
        end else if (reg_write) begin
            if (reg_addr == `CCA_ADDR_CONFIG) begin
                select <= reg_wdata[`CCA_SELECT_HI:`CCA_SELECT_LO];
                channel <= reg_wdata[`CCA_CHANNEL_HI:`CCA_CHANNEL_LO];
            end
            if (reg_addr == `CCA_ADDR_THRESH) begin
                limit <= reg_wdata[`CCA_LIMIT_HI:`CCA_LIMIT_LO];
            end
        end
    end

    // Registered read data, valid the cycle after the read strobe
    // Trigger bit and the reserved status bit always read zero
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `CCA_ADDR_STATUS:
                    reg_rdata <= {complete, idle_flag, 1'b0, trx_state_code};
                `CCA_ADDR_CONFIG:
                    reg_rdata <= {1'b0, select, channel};
                `CCA_ADDR_THRESH:
                    reg_rdata <= {4'h0, limit};
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
    end

    // Latest finished energy level, used when asked after a frame's
    // automatic measurement is already over
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_level <= 8'h00;
        end else if (meas_done) begin
            last_level <= meas_level;
        end
    end

    // Sequencer for one assessment; an accepted trigger picks the path
    // afresh from any state except ST_FINISH, so a cut-short run never raises its own
    // interrupt and the new run raises exactly one
    always @* begin
        next_state = state;
        if (accept) begin
            if (!in_receive) begin
                next_state = ST_FINISH;
            end else if (listening) begin
                next_state = ST_LISTEN;
            end else if (req_select == `CCA_SEL_CARRIER) begin
                next_state = ST_FINISH;
            end else if (auto_meas_active) begin
                next_state = ST_WAIT_AUTO;
            end else begin
                next_state = ST_FINISH;
            end
        end else begin
            case (state)
                ST_IDLE: begin
                    next_state = ST_IDLE;
                end
                ST_LISTEN: begin
                    // Ends once the window is over and the level is in,
                    // or at the deadline whatever the level source does
                    if (((count >= MEAS_LAST) && level_seen) ||
                        (count >= DEAD_LAST)) begin
                        next_state = ST_FINISH;
                    end
                end
                ST_WAIT_AUTO: begin
                    // Deadline bounds the wait on the frame's measurement
                    if (meas_done || (count >= DEAD_LAST)) begin
                        next_state = ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    next_state = ST_IDLE;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // State register
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Window timer, restarted by every accepted trigger
    // Counting on in the finishing cycle is harmless; the next trigger clears it
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= {CNT_W{1'b0}};
        end else if (accept) begin
            count <= {CNT_W{1'b0}};
        end else if (state != ST_IDLE) begin
            count <= count + 1'b1;
        end
    end

    // Measurement request, only when the window itself has to measure
    // A waiting or immediate run uses the frame's own measurement
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meas_start <= 1'b0;
        end else begin
            meas_start <= accept && in_receive && listening;
        end
    end

    // Detector captures; a restart clears whatever an aborted run saw
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            carrier_seen <= 1'b0;
            energy_seen <= 1'b0;
            level_seen <= 1'b0;
            measured <= 1'b0;
        end else if (accept) begin
            level_seen <= 1'b0;
            measured <= in_receive;
            // Busy receive means a sync header was found already
            carrier_seen <= in_receive && !listening &&
                            carrier_detect;
            energy_seen <= in_receive && !listening &&
                           !auto_meas_active && last_busy;
        end else begin
            // Carrier and level only count inside a running window or wait
            if (watching && carrier_detect) begin
                carrier_seen <= 1'b1;
            end
            if (watching && meas_done) begin
                level_seen <= 1'b1;
                if (level_busy) begin
                    energy_seen <= 1'b1;
                end
            end
        end
    end

    // Status bits and interrupt; completion set wins over trigger clear
    // Outside receive nothing was measured, so idle stays low
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            complete <= 1'b0;
            idle_flag <= 1'b0;
            done_irq <= 1'b0;
        end else begin
            done_irq <= 1'b0;
            if (finishing) begin
                complete <= 1'b1;
                idle_flag <= measured && !final_busy;
                done_irq <= 1'b1;
            end else if (trigger) begin
                complete <= 1'b0;
                idle_flag <= 1'b0;
            end
        end
    end
endmodule

//--- testbench/cca_properties.sv
`timescale 1ns/1ps
module cca_checker #(
    parameter MEAS_CYCLES = 20,
    parameter DEADLINE_CYCLES = 30
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Register port
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_rdata,
    // Receiver state and block outputs
    input wire [4:0] trx_state_code,
    input wire basic_mode,
    input wire rx_listen,
    input wire rx_busy,
    input wire preamble_detect_off,
    input wire auto_meas_active,
    input wire meas_start,
    input wire done_irq
);
    localparam int DLC = DEADLINE_CYCLES + 2;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Decoded trigger write and receiver situations
    wire trig = reg_write && reg_addr == 6'h08 && reg_wdata[7];
    wire lstn = basic_mode && (rx_listen || rx_busy && preamble_detect_off);
    wire brx = basic_mode && rx_busy && !preamble_detect_off;
    wire nrx = !basic_mode || !rx_listen && !rx_busy;
    wire carr = reg_wdata[6:5] == 2'h2;
    property p_req_zero; reg_read && reg_addr == 6'h08 |=> !reg_rdata[7]; endproperty
    a_req_zero: assert property (p_req_zero) else $error("trigger bit read as one");
    property p_lim_hi; reg_read && reg_addr == 6'h09 |=> reg_rdata[7:4] == 4'h0; endproperty
    a_lim_hi: assert property (p_lim_hi) else $error("threshold upper bits set");
    property p_sts; reg_read && reg_addr == 6'h01 |=>
        reg_rdata[5:0] == {1'h0, $past(trx_state_code)}; endproperty
    a_sts: assert property (p_sts) else $error("status low bits wrong");
    property p_norx; trig && nrx |-> ##2 done_irq; endproperty
    a_norx: assert property (p_norx) else $error("no completion outside receive");
    property p_lstart; trig && lstn |=> meas_start; endproperty
    a_lstart: assert property (p_lstart) else $error("listen start missing");
    property p_window; meas_start |=> !done_irq [*8]; endproperty
    a_window: assert property (p_window) else $error("window cut short");
    property p_dead; meas_start |-> ##[1:DLC] done_irq; endproperty
    a_dead: assert property (p_dead) else $error("result deadline missed");
    property p_carr; trig && brx && carr |-> ##2 done_irq; endproperty
    a_carr: assert property (p_carr) else $error("carrier mode not immediate");
    property p_after; trig && brx && !carr && !auto_meas_active |-> ##2 done_irq; endproperty
    a_after: assert property (p_after) else $error("late result not immediate");
    property p_wait; trig && brx && !carr && auto_meas_active |-> ##2 !done_irq; endproperty
    a_wait: assert property (p_wait) else $error("did not wait for measurement");
    property p_one; done_irq |=> !done_irq; endproperty
    a_one: assert property (p_one) else $error("interrupt longer than a cycle");
endmodule
bind clear_channel_assessment cca_checker #(.MEAS_CYCLES(MEAS_CYCLES),
    .DEADLINE_CYCLES(DEADLINE_CYCLES)) cca_checker_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .trx_state_code(trx_state_code), .basic_mode(basic_mode),
    .rx_listen(rx_listen), .rx_busy(rx_busy), .preamble_detect_off(preamble_detect_off),
    .auto_meas_active(auto_meas_active), .meas_start(meas_start), .done_irq(done_irq));

//--- testbench/meas_unit_model.sv
`timescale 1ns/1ps
module meas_unit_model (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Request and programmed answer
    input wire go,
    input wire [7:0] dly,
    input wire [7:0] level,
    // Result toward the block
    output reg meas_done,
    output reg [7:0] meas_level
);
    reg [7:0] cnt;
    // Level toggles outside the done cycle so stale data never looks valid
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 8'h00;
            meas_done <= 1'h0;
            meas_level <= 8'hFF;
        end else begin
            meas_done <= !go && cnt == 8'h01;
            meas_level <= (!go && cnt == 8'h01) ? level : ~meas_level;
            cnt <= go ? dly : (cnt != 8'h00 ? cnt - 8'h01 : cnt);
        end
    end
endmodule

//--- testbench/clear_channel_assessment_tb_top.sv
`timescale 1ns/1ps
module clear_channel_assessment_tb_top;
    reg ref_clk = 1'h0, rst_b = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
    reg basic_mode = 1'h0, rx_listen = 1'h0, rx_busy = 1'h0, preamble_detect_off = 1'h0;
    reg carrier_detect = 1'h0, auto_meas_active = 1'h0, kick = 1'h0;
    reg [5:0] reg_addr = 6'h00;
    reg [7:0] reg_wdata = 8'h00, dly = 8'h04, lvl = 8'h00;
    reg [4:0] trx_state_code = 5'h06;
    reg [3:0] lim = 4'h0;
    reg [31:0] seed = 32'hAEE6;
    wire meas_done, meas_start, done_irq;
    wire [4:0] channel_number;
    wire [7:0] meas_level, reg_rdata;
    integer errors = 0, checks = 0, irqs = 0, i, n;
    always #12.5 ref_clk = ~ref_clk;
    clear_channel_assessment #(.MEAS_CYCLES(20), .DEADLINE_CYCLES(30))
    clear_channel_assessment_inst (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .trx_state_code(trx_state_code), .basic_mode(basic_mode),
        .rx_listen(rx_listen), .rx_busy(rx_busy), .preamble_detect_off(preamble_detect_off),
        .carrier_detect(carrier_detect), .auto_meas_active(auto_meas_active),
        .meas_done(meas_done), .meas_level(meas_level), .meas_start(meas_start),
        .channel_number(channel_number), .done_irq(done_irq));
    meas_unit_model meas_unit_model_inst (.ref_clk(ref_clk), .rst_b(rst_b),
        .go(meas_start | kick), .dly(dly), .level(lvl), .meas_done(meas_done),
        .meas_level(meas_level));
    // Interrupt tally, one per completed assessment; a retrigger that cuts a run short adds none
    always @(posedge ref_clk) if (done_irq === 1'h1) irqs = irqs + 1;
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Idle flag from mode, carrier, level and limit (limit is in 2 dB steps)
    function idle(input [1:0] md, input c, input [7:0] l, input [3:0] t);
        reg e;
        begin
            e = l > {3'h0, t, 1'h0};
            idle = md == 2'h0 ? !(c | e) : md == 2'h1 ? !e : md == 2'h2 ? !c : !(c & e);
        end
    endfunction
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // Each access ends with an idle cycle so strobes never re-rise in one step
    task acc(input w, input [5:0] a, input [7:0] d);
        begin
            reg_addr = a;
            reg_wdata = d;
            reg_write = w;
            reg_read = !w;
            @(posedge ref_clk) #2;
            reg_write = 1'h0;
            reg_read = 1'h0;
            @(posedge ref_clk) #2;
        end
    endtask
    task rd(input [5:0] a, input [7:0] e, input string nm);
        begin
            acc(1'h0, a, 8'h00);
            chk(nm, reg_rdata, e);
        end
    endtask
    task wait_irq;
        begin
            n = 0;
            while (done_irq !== 1'h1 && n < 60) begin
                @(posedge ref_clk) #2;
                n = n + 1;
            end
            chk("irq", {7'h00, done_irq}, 8'h01);
        end
    endtask
    task test_done;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        #(25 * 5000);
        errors = errors + 1;
        test_done;
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        #2 rst_b = 1'h1;
        rd(6'h08, 8'h2B, "cfg_rst");
        rd(6'h09, 8'h07, "thr_rst");
        rd(6'h01, 8'h06, "sts_rst");
        chk("chan_rst", {3'h0, channel_number}, 8'h0B);
        acc(1'h1, 6'h02, 8'hFF);
        rd(6'h02, 8'h00, "unmapped");
        // Config write without the trigger bit: fields only, no assessment
        acc(1'h1, 6'h08, 8'h55);
        chk("chan", {3'h0, channel_number}, 8'h15);
        rd(6'h08, 8'h55, "cfg_wr");
        // Not in a receive state: completes without measuring
        acc(1'h1, 6'h08, 8'hAB);
        wait_irq;
        rd(6'h01, 8'h86, "sts_norx");
        rd(6'h08, 8'h2B, "cfg_clr");
        basic_mode = 1'h1;
        rx_listen = 1'h1;
        // Listen: every mode twice, last two with preamble detect off in busy receive
        for (i = 0; i < 8; i = i + 1) begin
            seed = lfsr(seed);
            lim = seed[3:0];
            lvl = i == 4 ? {3'h0, seed[3:0], 1'h0} : {2'h0, seed[9:4]};
            carrier_detect = seed[10];
            dly = 8'h03 + {4'h0, seed[14:11]};
            if (i == 6) {rx_listen, rx_busy, preamble_detect_off} = 3'h3;
            acc(1'h1, 6'h09, {4'h0, lim});
            acc(1'h1, 6'h08, {1'h1, i[1:0], 5'h0B});
            rd(6'h01, 8'h06, "sts_clear");
            wait_irq;
            rd(6'h01, {1'h1, idle(i[1:0], carrier_detect, lvl, lim), 6'h06}, "sts_lst");
        end
        // Busy receive: with and without a running automatic measurement
        {rx_listen, rx_busy, preamble_detect_off} = 3'h2;
        for (i = 0; i < 8; i = i + 1) begin
            seed = lfsr(seed);
            carrier_detect = seed[0];
            auto_meas_active = i[2];
            acc(1'h1, 6'h08, {1'h1, i[1:0], 5'h0B});
            if (i[2] && i[1:0] != 2'h2) begin
                lvl = {2'h0, seed[6:1]};
                kick = 1'h1;
                @(posedge ref_clk) #2;
                kick = 1'h0;
            end
            wait_irq;
            rd(6'h01, {1'h1, idle(i[1:0], carrier_detect, lvl, lim), 6'h06}, "sts_brx");
        end
        // Retrigger while listening restarts, one interrupt only
        {rx_listen, rx_busy, auto_meas_active} = 3'h4;
        acc(1'h1, 6'h08, 8'hAB);
        acc(1'h1, 6'h08, 8'hAB);
        wait_irq;
        repeat (40) @(posedge ref_clk);
        chk("irq_count", irqs[7:0], 8'd18);
        test_done;
    end
endmodule
